/* hw/jta_top.sv */
//
// Overview of operation
// - Controller state moves only on TMS, sampled by the test clock.
// - Either instruction path or one data register sits between TDI and TDO.
// - Held instruction picks the data register and its behaviour.
// - Identification, one-bit bypass and boundary chain serve board test.
// - Programming uses one instruction-selected data register.
// - Internal and breakpoint chains reachable only with debug enabled.
// - Port is exactly four signals: TMS, TCK, TDI, TDO.
// - All port state and shifting runs on the test clock.
// - TDI data shifts into the selected register.
// - TDO carries the bit leaving the selected register.
// - No test reset pin; reset by power-on or TMS sequence.
// - Fuse unprogrammed: pins are ordinary port pins, controller held reset.
// - Fuse set and disable clear: inputs pulled up, port enabled.
// - TDO driven only in shift states, otherwise released.
// - Enable fuse reads programmed as delivered.
// - Sixteen states; test-logic-reset after power-on.
// - Every chain shifts least significant bit first.
// - Instruction path shifts out captured 0x01.
// - Five clocks of TMS high reach test-logic-reset from anywhere.
//
`timescale 1ns/10ps
`default_nettype none
`include "jta_params.svh"

module jta_top (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo_o,
    output logic                      tdo_oe,
    input  wire logic                 test_port_enable_fuse,
    input  wire logic                 test_port_disable_bit,
    input  wire logic                 ocd_enable,
    input  wire logic [`JTA_BSC_W-1:0] bsc_pin_in,
    output logic      [`JTA_BSC_W-1:0] bsc_pin_out,
    output logic                      bsc_drive,
    output logic                      tap_pins_own,
    output logic                      tap_pullup_en,
    output logic                      xf_valid,
    output jta_pkg::jta_xsel_e        xf_sel,
    output logic      [`JTA_XF_W-1:0] xf_data
);
    import jta_pkg::*;

    typedef struct packed {
        logic en;
    } jta_sys_s;

    localparam jta_tck_s TCK_RST = '{
        st:   JTA_TLR,
        ir:   `JTA_I_IDCODE,
        sh:   '0,
        bsc:  '0,
        drv:  1'b0,
        tog:  1'b0,
        xsel: JTA_XF_PROG,
        xdat: '0
    };

    jta_sys_s               sys_ff;
    jta_sys_s               nxt_sys;
    jta_tck_s               tck_ff;
    jta_tck_s               nxt_tck;
    logic                   tdo_ff;
    logic                   tdo_oe_ff;
    logic                   s_rstn;
    logic                   s_en;
    logic                   s_ocd;
    logic [`JTA_BSC_W-1:0]  s_bsc;
    logic                   tap_rst;
    logic [`JTA_IR_W-1:0]   eff_ir;

    jta_xfer_if xf ();

    // Standard controller walk on one TMS sample
    function automatic jta_tap_e tap_next(input jta_tap_e s, input logic m);
        jta_tap_e n;
        n = s;
        case (s)
            JTA_TLR:    n = m ? JTA_TLR    : JTA_RTI;
            JTA_RTI:    n = m ? JTA_SEL_DR : JTA_RTI;
            JTA_SEL_DR: n = m ? JTA_SEL_IR : JTA_CAP_DR;
            JTA_CAP_DR: n = m ? JTA_EX1_DR : JTA_SH_DR;
            JTA_SH_DR:  n = m ? JTA_EX1_DR : JTA_SH_DR;
            JTA_EX1_DR: n = m ? JTA_UPD_DR : JTA_PAU_DR;
            JTA_PAU_DR: n = m ? JTA_EX2_DR : JTA_PAU_DR;
            JTA_EX2_DR: n = m ? JTA_UPD_DR : JTA_SH_DR;
            JTA_UPD_DR: n = m ? JTA_SEL_DR : JTA_RTI;
            JTA_SEL_IR: n = m ? JTA_TLR    : JTA_CAP_IR;
            JTA_CAP_IR: n = m ? JTA_EX1_IR : JTA_SH_IR;
            JTA_SH_IR:  n = m ? JTA_EX1_IR : JTA_SH_IR;
            JTA_EX1_IR: n = m ? JTA_UPD_IR : JTA_PAU_IR;
            JTA_PAU_IR: n = m ? JTA_EX2_IR : JTA_PAU_IR;
            JTA_EX2_IR: n = m ? JTA_UPD_IR : JTA_SH_IR;
            JTA_UPD_IR: n = m ? JTA_SEL_DR : JTA_RTI;
            default:    n = JTA_TLR;
        endcase
        return n;
    endfunction : tap_next

    // Instruction in force; debug chains fall back to bypass when locked
    function automatic logic [`JTA_IR_W-1:0] sel_ir(
        input logic [`JTA_IR_W-1:0] i,
        input logic                 ocd
    );
        logic [`JTA_IR_W-1:0] r;
        r = `JTA_I_BYPASS;
        if (i == `JTA_I_EXTEST || i == `JTA_I_SAMPLE || i == `JTA_I_IDCODE) begin
            r = i;
        end else if (i == `JTA_I_PROG) begin
            r = i;
        end else if ((i == `JTA_I_DSCAN || i == `JTA_I_DBRK) && ocd) begin
            r = i;
        end
        return r;
    endfunction : sel_ir

    // Length of the chain behind an instruction in force
    function automatic logic [5:0] dr_len(input logic [`JTA_IR_W-1:0] i);
        logic [5:0] l;
        l = `JTA_LEN_BYP;
        if (i == `JTA_I_IDCODE) begin
            l = `JTA_LEN_ID;
        end else if (i == `JTA_I_EXTEST || i == `JTA_I_SAMPLE) begin
            l = `JTA_LEN_BSC;
        end else if (i == `JTA_I_PROG || i == `JTA_I_DSCAN || i == `JTA_I_DBRK) begin
            l = `JTA_LEN_XF;
        end
        return l;
    endfunction : dr_len

    // Shift right one place, new bit enters at the chain's far end
    function automatic logic [`JTA_SH_W-1:0] shift_in(
        input logic [`JTA_SH_W-1:0] s,
        input logic                 b,
        input logic [5:0]           len
    );
        logic [`JTA_SH_W-1:0] r;
        r = s >> 1;
        r[len[4:0] - 5'd1] = b;
        return r;
    endfunction : shift_in

    function automatic logic is_shift(input jta_tap_e s);
        return (s == JTA_SH_DR) || (s == JTA_SH_IR);
    endfunction : is_shift

    // Enable is a plain level in the system domain
    always_comb begin
        nxt_sys.en = test_port_enable_fuse & ~test_port_disable_bit;
    end

    // Reset value of the enable follows the shipped fuse state
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sys_ff <= '{en: `JTA_FUSE_RST};
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // Pins belong to the port only while enabled, pull-ups with them
    assign tap_pins_own  = sys_ff.en;
    assign tap_pullup_en = sys_ff.en;

    // Levels entering the test clock domain
    jta_sync #(.W(3 + `JTA_BSC_W)) u_sync (
        .clk (tck),
        .d   ({rstn, sys_ff.en, ocd_enable, bsc_pin_in}),
        .q   ({s_rstn, s_en, s_ocd, s_bsc})
    );

    // Power-on reset or a disabled port holds the controller; no reset pin
    assign tap_rst = ~(s_rstn & s_en);
    assign eff_ir  = sel_ir(tck_ff.ir, s_ocd);

    // Controller, instruction and data paths, all on the test clock
    always_comb begin
        nxt_tck    = tck_ff;
        nxt_tck.st = tap_next(tck_ff.st, tms);
        case (tck_ff.st)
            JTA_TLR: begin
                nxt_tck.ir  = `JTA_I_IDCODE;
                nxt_tck.drv = 1'b0;
            end
            JTA_CAP_IR: begin
                nxt_tck.sh = {{(`JTA_SH_W-`JTA_IR_W){1'b0}}, `JTA_IR_CAPT};
            end
            JTA_SH_IR: begin
                nxt_tck.sh = shift_in(tck_ff.sh, tdi, `JTA_LEN_IR);
            end
            JTA_UPD_IR: begin
                nxt_tck.ir  = tck_ff.sh[`JTA_IR_W-1:0];
                nxt_tck.drv = (tck_ff.sh[`JTA_IR_W-1:0] == `JTA_I_EXTEST);
            end
            JTA_CAP_DR: begin
                // Parallel capture depends on the chain in use
                if (eff_ir == `JTA_I_IDCODE) begin
                    nxt_tck.sh = `JTA_ID_CODE;
                end else if (eff_ir == `JTA_I_EXTEST || eff_ir == `JTA_I_SAMPLE) begin
                    nxt_tck.sh = {{(`JTA_SH_W-`JTA_BSC_W){1'b0}}, s_bsc};
                end else if (eff_ir == `JTA_I_BYPASS) begin
                    nxt_tck.sh = '0;
                end else begin
                    nxt_tck.sh = {{(`JTA_SH_W-`JTA_XF_W){1'b0}}, tck_ff.xdat};
                end
            end
            JTA_SH_DR: begin
                nxt_tck.sh = shift_in(tck_ff.sh, tdi, dr_len(eff_ir));
            end
            JTA_UPD_DR: begin
                // Boundary latch for pins, programming and debug chains go to the system
                if (eff_ir == `JTA_I_EXTEST || eff_ir == `JTA_I_SAMPLE) begin
                    nxt_tck.bsc = tck_ff.sh[`JTA_BSC_W-1:0];
                end else if (eff_ir == `JTA_I_PROG) begin
                    nxt_tck.xsel = JTA_XF_PROG;
                    nxt_tck.xdat = tck_ff.sh[`JTA_XF_W-1:0];
                    nxt_tck.tog  = ~tck_ff.tog;
                end else if (eff_ir == `JTA_I_DSCAN || eff_ir == `JTA_I_DBRK) begin
                    nxt_tck.xsel = (eff_ir == `JTA_I_DSCAN) ? JTA_XF_DSCAN : JTA_XF_DBRK;
                    nxt_tck.xdat = tck_ff.sh[`JTA_XF_W-1:0];
                    nxt_tck.tog  = ~tck_ff.tog;
                end
            end
            default: begin
                nxt_tck.sh = tck_ff.sh;
            end
        endcase
    end

    // Toggle survives a disable so the system side sees no false word
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            tck_ff <= TCK_RST;
            if (s_rstn) begin
                tck_ff.tog <= tck_ff.tog;
            end
        end else begin
            tck_ff <= nxt_tck;
        end
    end

    // Output changes half a clock after the shift, away from the sample edge
    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else begin
            tdo_ff    <= tck_ff.sh[0];
            tdo_oe_ff <= is_shift(tck_ff.st);
        end
    end

    assign tdo_o       = tdo_ff;
    assign tdo_oe      = tdo_oe_ff;
    assign bsc_pin_out = tck_ff.bsc;
    assign bsc_drive   = tck_ff.drv;

    // Words for the programming and debug logic cross by toggle
    assign xf.tog = tck_ff.tog;
    assign xf.sel = tck_ff.xsel;
    assign xf.dat = tck_ff.xdat;

    jta_xfer_rx u_rx (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .xf      (xf),
        .vld     (xf_valid),
        .sel     (xf_sel),
        .dat     (xf_data)
    );

    // Checks on the test clock domain
    default clocking tap_cb @(posedge tck);
    endclocking
    default disable iff (tap_rst);

    tms_five_a: assert property (tms [*5] |=> tck_ff.st == JTA_TLR)
        else $error("five TMS highs did not reach reset state");

    idle_hold_a: assert property (
        tck_ff.st == JTA_RTI && !tms |=> tck_ff.st == JTA_RTI)
        else $error("idle state left with TMS low");

    ir_capture_a: assert property (
        tck_ff.st == JTA_CAP_IR |=> tck_ff.sh[3:0] == 4'h1)
        else $error("instruction capture value wrong");

    ir_update_a: assert property (
        tck_ff.st == JTA_UPD_IR |=> tck_ff.ir == $past(tck_ff.sh[3:0]))
        else $error("instruction not latched on update");

    lsb_first_a: assert property (
        tck_ff.st == JTA_SH_IR |=> tck_ff.sh[3] == $past(tdi)
            && tck_ff.sh[2:0] == $past(tck_ff.sh[3:1]))
        else $error("instruction shift order wrong");

    bypass_one_a: assert property (
        tck_ff.st == JTA_SH_DR && eff_ir == 4'hf |=> tck_ff.sh[0] == $past(tdi))
        else $error("bypass is not a single stage");

    idcode_cap_a: assert property (
        tck_ff.st == JTA_CAP_DR && eff_ir == 4'h1 |=> tck_ff.sh == 32'h0a5c_3e11)
        else $error("identification word not captured");

    dbg_locked_a: assert property (
        tck_ff.ir == 4'h8 && !s_ocd |-> eff_ir == 4'hf)
        else $error("debug chain reachable while locked");

    // Split in two so the unset synchroniser before first reset fires nothing
    tdo_float_a: assert property (
        !(tck_ff.st == JTA_SH_DR || tck_ff.st == JTA_SH_IR) |-> !tdo_oe)
        else $error("output enable outside shift states");

    tdo_drive_a: assert property (
        (tck_ff.st == JTA_SH_DR || tck_ff.st == JTA_SH_IR) |-> tdo_oe)
        else $error("output not driven in shift state");

    // Bypass is one stage deep, so its output bit is the TDI bit just taken
    tdo_data_a: assert property (
        tdo_oe ##1 tdo_oe |-> tdo_o == ($past(tck_ff.st == JTA_SH_DR && eff_ir == 4'hf)
            ? $past(tdi) : $past(tck_ff.sh[1])))
        else $error("output bit not from shift path");

    reset_state_a: assert property (
        @(posedge tck) $past(tap_rst) |-> tck_ff.st == JTA_TLR)
        else $error("controller not in reset state after reset");

    ir_shift_c: cover property (
        tck_ff.st == JTA_CAP_IR ##1 tck_ff.st == JTA_SH_IR [*4] ##1 tck_ff.st == JTA_EX1_IR);

    prog_upd_c: cover property (
        tck_ff.st == JTA_UPD_DR && eff_ir == 4'h4);

    bsc_upd_c: cover property (
        tck_ff.st == JTA_UPD_DR && eff_ir == 4'h0);

    tms_escape_c: cover property (
        tck_ff.st == JTA_SH_DR ##1 tms [*5] ##1 tck_ff.st == JTA_TLR);

endmodule : jta_top

`default_nettype wire

/* hw/jta_params.svh */
`ifndef JTA_PARAMS_SVH
`define JTA_PARAMS_SVH

// Shift path widths
`define JTA_IR_W       4
`define JTA_SH_W       32
`define JTA_BSC_W      8
`define JTA_XF_W       16

// Chain lengths as shift-path lengths
`define JTA_LEN_IR     6'd4
`define JTA_LEN_ID     6'd32
`define JTA_LEN_BYP    6'd1
`define JTA_LEN_BSC    6'd8
`define JTA_LEN_XF     6'd16

// Value loaded into the instruction path on capture
`define JTA_IR_CAPT    4'h1

// Identification word, arbitrary value, bit 0 set as the standard asks
`define JTA_ID_CODE    32'h0a5c_3e11

// Instruction codes
`define JTA_I_EXTEST   4'h0
`define JTA_I_IDCODE   4'h1
`define JTA_I_SAMPLE   4'h2
`define JTA_I_PROG     4'h4
`define JTA_I_DSCAN    4'h8
`define JTA_I_DBRK     4'h9
`define JTA_I_BYPASS   4'hf

// Port enable fuse as delivered
`define JTA_FUSE_RST   1'b1

// Clocks of TMS high that force test-logic-reset
`define JTA_TMS_RST_N  5

`endif

/* hw/jta_pkg.sv */
`default_nettype none
`include "jta_params.svh"

package jta_pkg;

    // Sixteen controller states
    typedef enum logic [3:0] {
        JTA_TLR    = 4'h0,
        JTA_RTI    = 4'h1,
        JTA_SEL_DR = 4'h2,
        JTA_CAP_DR = 4'h3,
        JTA_SH_DR  = 4'h4,
        JTA_EX1_DR = 4'h5,
        JTA_PAU_DR = 4'h6,
        JTA_EX2_DR = 4'h7,
        JTA_UPD_DR = 4'h8,
        JTA_SEL_IR = 4'h9,
        JTA_CAP_IR = 4'ha,
        JTA_SH_IR  = 4'hb,
        JTA_EX1_IR = 4'hc,
        JTA_PAU_IR = 4'hd,
        JTA_EX2_IR = 4'he,
        JTA_UPD_IR = 4'hf
    } jta_tap_e;

    // Target of a word handed to the system side
    typedef enum logic [1:0] {
        JTA_XF_PROG  = 2'h0,
        JTA_XF_DSCAN = 2'h1,
        JTA_XF_DBRK  = 2'h2
    } jta_xsel_e;

    // State of the test clock domain
    typedef struct packed {
        jta_tap_e                st;
        logic [`JTA_IR_W-1:0]    ir;
        logic [`JTA_SH_W-1:0]    sh;
        logic [`JTA_BSC_W-1:0]   bsc;
        logic                    drv;
        logic                    tog;
        jta_xsel_e               xsel;
        logic [`JTA_XF_W-1:0]    xdat;
    } jta_tck_s;

endpackage : jta_pkg

`default_nettype wire

/* hw/jta_xfer_if.sv */
`timescale 1ns/10ps
`default_nettype none
`include "jta_params.svh"

// Word handed from the test clock domain; tog flips once per word
interface jta_xfer_if;
    import jta_pkg::*;
    logic                  tog;
    jta_xsel_e             sel;
    logic [`JTA_XF_W-1:0]  dat;
    modport src (output tog, output sel, output dat);
    modport dst (input tog, input sel, input dat);
endinterface : jta_xfer_if

`default_nettype wire

/* hw/jta_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser; only the second stage is visible
module jta_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } jta_sync_s;

    jta_sync_s sync_ff;
    jta_sync_s nxt_sync;

    // No reset: the stages settle within two edges
    always_comb begin
        nxt_sync.meta = d;
        nxt_sync.held = sync_ff.meta;
    end

    always_ff @(posedge clk) begin
        sync_ff <= nxt_sync;
    end

    assign q = sync_ff.held;
endmodule : jta_sync

`default_nettype wire

/* hw/jta_xfer_rx.sv */
`timescale 1ns/10ps
`default_nettype none
`include "jta_params.svh"

// System side of the word crossing
module jta_xfer_rx (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    jta_xfer_if.dst                   xf,
    output logic                      vld,
    output jta_pkg::jta_xsel_e        sel,
    output logic [`JTA_XF_W-1:0]      dat
);
    import jta_pkg::*;

    typedef struct packed {
        logic                  tog;
        logic                  vld;
        jta_xsel_e             sel;
        logic [`JTA_XF_W-1:0]  dat;
    } jta_rx_s;

    jta_rx_s rx_ff;
    jta_rx_s nxt_rx;
    logic    tog_s;

    jta_sync #(.W(1)) u_tog (
        .clk (sys_clk),
        .d   (xf.tog),
        .q   (tog_s)
    );

    // Word is held stable since the toggle, so a plain capture is safe
    always_comb begin
        nxt_rx     = rx_ff;
        nxt_rx.tog = tog_s;
        nxt_rx.vld = tog_s ^ rx_ff.tog;
        if (tog_s ^ rx_ff.tog) begin
            nxt_rx.sel = xf.sel;
            nxt_rx.dat = xf.dat;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rx_ff <= '{tog: 1'b0, vld: 1'b0, sel: JTA_XF_PROG, dat: '0};
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    assign vld = rx_ff.vld;
    assign sel = rx_ff.sel;
    assign dat = rx_ff.dat;
endmodule : jta_xfer_rx

`default_nettype wire

/* dv/jta_tester_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Outside tester: drives the link, its clock stands still between frames
module jta_tester_model #(
    parameter int HALF = 40
) (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic sys_rstn
);
    int gap = 0;  // Idle time before a frame, to look like a slow tester
    int n_resets = 0;  // Falls of the system reset line seen so far

    // Debugger watches the shared reset line for resets from outside
    always @(negedge sys_rstn) n_resets++;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock period; TDO is taken just before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        #(HALF);
        q = tdo;
        tck <= 1'b1;
        #(HALF);
        tck <= 1'b0;
    endtask : step

    // No reset pin, so five periods of TMS high are the only way back
    task automatic reset5();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
    endtask : reset5

    // Full scan from idle; last bit leaves Shift with TMS high
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        #(gap + 1.3);  // Keeps test clock edges off the system clock edges
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], q);
            dout[k] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : jta_tester_model

`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "jta_params.svh"

module tb;
    import jta_pkg::*;
    logic                  sys_clk;
    logic                  rstn;
    logic                  tck;
    logic                  tms;
    logic                  tdi;
    logic                  tdo_o;
    logic                  tdo_oe;
    logic                  tdo_pin;
    logic                  fuse;
    logic                  dis;
    logic                  ocd;
    logic [`JTA_BSC_W-1:0] pins_in;
    logic [`JTA_BSC_W-1:0] pins_out;
    logic                  bsc_drive;
    logic                  own;
    logic                  pull;
    logic                  xf_valid;
    jta_xsel_e             xf_sel;
    logic [`JTA_XF_W-1:0]  xf_data;
    logic [`JTA_XF_W-1:0]  last_word = '0;
    logic [3:0]            codes [8] = '{`JTA_I_EXTEST, `JTA_I_IDCODE, `JTA_I_SAMPLE, 4'h3,
                                         `JTA_I_PROG, `JTA_I_DSCAN, `JTA_I_DBRK, `JTA_I_BYPASS};
    int                    fail_count = 0;
    int                    n_checks = 0;
    int                    n_words = 0;

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    // Pull-up holds the released line high
    assign tdo_pin = tdo_oe ? tdo_o : 1'b1;

    // Words arriving on the system side
    always @(posedge sys_clk) begin
        if (xf_valid === 1'b1) n_words <= n_words + 1;
    end

    jta_top i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe), .test_port_enable_fuse(fuse),
        .test_port_disable_bit(dis), .ocd_enable(ocd), .bsc_pin_in(pins_in),
        .bsc_pin_out(pins_out), .bsc_drive(bsc_drive), .tap_pins_own(own),
        .tap_pullup_en(pull), .xf_valid(xf_valid), .xf_sel(xf_sel), .xf_data(xf_data)
    );

    jta_tester_model i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin),
                               .sys_rstn(rstn));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_flag

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // Serial output of a chain of len bits: captured bits first, then TDI
    function automatic logic [31:0] exp_out(input int len, input logic [31:0] cap,
                                            input logic [31:0] din);
        logic [31:0] r;
        for (int k = 0; k < 32; k++) r[k] = (k < len) ? cap[k] : din[k - len];
        return r;
    endfunction : exp_out

    // Back to idle by TMS only, then the identification word must come out
    task automatic idle_id();
        logic        q;
        logic [31:0] dout;
        i_tester.reset5();
        i_tester.step(1'b0, 1'b0, q);
        i_tester.scan(1'b0, 32, 32'($urandom()), dout);
        check_word(dout, `JTA_ID_CODE);
    endtask : idle_id

    // Reset held while the tester clocks, as the sync into tck needs edges
    task automatic power_up();
        @(posedge sys_clk) rstn <= 1'b0;
        fork
            i_tester.reset5();
            repeat (20) @(posedge sys_clk);
        join
        check_flag(tdo_oe, 1'b0);
        check_flag(own, 1'b1);
        check_flag(xf_valid, 1'b0);
        @(posedge sys_clk) rstn <= 1'b1;
        idle_id();
        check_word(32'(xf_data), 32'h0);
        last_word = '0;
    endtask : power_up

    // Load one instruction, then a 32-bit data scan through its chain
    task automatic run_instr(input logic [3:0] code);
        logic [31:0] din;
        logic [31:0] dout;
        logic [31:0] cap;
        int          len;
        int          w0;
        logic        word;
        din = $urandom();
        i_tester.gap = $urandom_range(200);
        @(posedge sys_clk) pins_in <= `JTA_BSC_W'($urandom());
        i_tester.scan(1'b1, 4, 32'(code), dout);
        check_word(dout, 32'(`JTA_IR_CAPT));
        word = 1'b0;
        len = 1;
        cap = '0;
        case (code)
            `JTA_I_IDCODE: begin
                len = 32;
                cap = `JTA_ID_CODE;
            end
            `JTA_I_EXTEST, `JTA_I_SAMPLE: begin
                len = 8;
                cap = 32'(pins_in);
            end
            `JTA_I_PROG: word = 1'b1;
            `JTA_I_DSCAN, `JTA_I_DBRK: word = ocd;
            default: ;
        endcase
        if (word) begin
            len = 16;
            cap = 32'(last_word);
        end
        w0 = n_words;
        i_tester.scan(1'b0, 32, din, dout);
        check_word(dout, exp_out(len, cap, din));
        check_flag(tdo_oe, 1'b0);
        check_flag(bsc_drive, code == `JTA_I_EXTEST);
        if (len == 8) check_word(32'(pins_out), 32'(din[31:24]));
        check_word(32'(n_words - w0), 32'(word));
        if (word) begin
            last_word = din[31:16];
            check_word(32'(xf_data), 32'(last_word));
            check_word(32'(xf_sel), 32'(code == `JTA_I_PROG ? JTA_XF_PROG :
                       code == `JTA_I_DSCAN ? JTA_XF_DSCAN : JTA_XF_DBRK));
        end
    endtask : run_instr

    initial begin
        logic        q;
        logic [31:0] dout;
        int          n_rst;
        rstn = 1'b0;
        fuse = 1'b1;
        dis = 1'b0;
        ocd = 1'b0;
        pins_in = '0;
        void'($urandom(32'h5078));
        power_up();
        check_flag(pull, 1'b1);
        // Every code with debug chains locked, then unlocked
        for (int o = 0; o < 2; o++) begin
            @(posedge sys_clk) ocd <= o[0];
            foreach (codes[i]) run_instr(codes[i]);
        end
        // Random TMS walks must always be recoverable
        repeat (4) begin
            repeat (1 + $urandom_range(11)) i_tester.step(1'($urandom()), 1'($urandom()), q);
            idle_id();
        end
        // Fuse unprogrammed, then disable bit set: pins released, controller held reset
        for (int c = 0; c < 2; c++) begin
            @(posedge sys_clk) begin
                fuse <= c[0];
                dis <= c[0];
            end
            i_tester.reset5();
            check_flag(own, 1'b0);
            check_flag(pull, 1'b0);
            i_tester.scan(1'b1, 4, 32'h0, dout);
            check_word(dout, 32'hf);
        end
        @(posedge sys_clk) begin
            fuse <= 1'b1;
            dis <= 1'b0;
        end
        // Disable reset cleared the word the system chains capture
        last_word = '0;
        idle_id();
        run_instr(`JTA_I_PROG);
        n_rst = i_tester.n_resets;
        power_up();
        check_word(32'(i_tester.n_resets - n_rst), 32'h1);
        run_instr(`JTA_I_BYPASS);
        give_verdict();
    end

    // Whole run needs well under 150 us
    initial begin
        #300_000;
        fail_count++;
        give_verdict();
    end
endmodule : tb

`default_nettype wire
